// *** ircic_pkg.sv ***
// Purpose: constants for the internal-Internal_state_a clock control block
// Assumes: 50 MHz clk_sys, AXI4-Lite register access
// Notes: register offsets are byte addresses, one word each
package ircic_pkg;
  localparam logic [7:0]  CTRL_OFS   = 8'h00;
  localparam logic [7:0]  STAT_OFS   = 8'h04;
  localparam logic [7:0]  STAB_OFS   = 8'h08;
  localparam logic [7:0]  SWD_OFS    = 8'h0c;
  localparam logic [7:0]  IRQS_OFS   = 8'h10;
  localparam logic [7:0]  IMSK_OFS   = 8'h14;
  // Control register fields
  localparam int CTL_IDLE    = 0;
  localparam int CTL_SCS_LO  = 1;
  localparam int CTL_SCS_HI  = 2;
  localparam int CTL_SRC     = 3;
  localparam int CTL_MFP     = 4;
  localparam int CTL_WDT     = 5;
  localparam int CTL_FSCM    = 6;
  localparam int CTL_FRQ_LSB = 8;
  localparam int FRQ_W       = 3;
  // Status bit positions
  localparam int ST_PRI  = 0;
  localparam int ST_HFS  = 1;
  localparam int ST_MFS  = 2;
  localparam int ST_CPU  = 3;
  localparam int ST_OSCE = 4;
  localparam int ST_LFRC = 5;
  localparam int ST_IDLE = 6;
  // Interrupt event bit positions
  localparam int EV_IDLE = 0;
  localparam int EV_WAKE = 1;
  localparam int EV_STAB = 2;
  localparam int EV_W    = 3;
  // Reset values and default delays
  localparam logic [31:0] CTRL_RST      = 32'h0000_0000;
  localparam int          CNT_W         = 16;
  localparam int          CLK_NS        = 20;
  localparam int          STAB_TIME_NS  = 1000;
  localparam int          SWD_TIME_NS   = 200;
  localparam logic [15:0] STAB_CYC_RST  = 16'((STAB_TIME_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] SWD_CYC_RST   = 16'((SWD_TIME_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [1:0]  RESP_OKAY     = 2'b00;
  localparam logic [1:0]  RESP_SLVERR   = 2'b10;
  typedef enum logic [1:0] {ST_RUN_PRI, ST_RUN_INT, ST_IDLE_INT, ST_WAKE} ircic_state_t;
endpackage

// *** ircic_delay.sv ***
// Purpose: one-shot cycle counter for stabilization and switch delays
// Assumes: start is a one-cycle pulse; len of zero acts as one
// Notes: done is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
module ircic_delay
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        start,
  input  wire logic        abort,
  input  wire logic [15:0] len,
  output logic             busy,
  output logic             done
);
  logic [15:0] cnt_r;

  // Load on start, count down, pulse at end
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_r <= 16'h0000;
      busy  <= 1'b0;
      done  <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (abort)
      begin
        busy <= 1'b0;
      end
      else if (start)
      begin
        cnt_r <= (len == 16'h0000) ? 16'h0001 : len;
        busy  <= 1'b1;
      end
      else if (busy)
      begin
        if (cnt_r == 16'h0001)
        begin
          busy <= 1'b0;
          done <= 1'b1;
        end
        cnt_r <= cnt_r - 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

// *** ircic_top.sv ***
// Purpose: internal-Internal_state_a clock control with AXI4-Lite registers
// Assumes: sleep_exec and wake_event are same-clock one-cycle pulses
// Notes: oscillator stable flags come from the stabilization counter, there is no ready input
`timescale 1ns/1ps
`default_nettype none
module ircic_top
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        sleep_exec,
  input  wire logic        wake_event,
  output logic             cpu_clk_en,
  output logic             periph_clk_en,
  output logic             primary_osc_en,
  output logic             internal_osc_en,
  output logic [2:0]       periph_freq_sel,
  output logic             low_freq_rc_en,
  output logic             irq
);
  logic [31:0]            ctrl_r;
  logic [15:0]            stab_len_r;
  logic [15:0]            swd_len_r;
  logic [2:0]             irqs_r;
  logic [2:0]             imsk_r;
  ircic_pkg::ircic_state_t state_r;
  logic                   pri_run_r;
  logic                   hf_osc_stable_flag;
  logic                   mf_osc_stable_flag;
  logic                   osc_want;
  logic                   osc_want_q;
  logic                   stab_busy;
  logic                   stab_done;
  logic                   swd_busy;
  logic                   swd_done;
  logic                   enter_idle;
  logic [2:0]             ev;
  logic                   aw_ok;
  logic                   w_ok;
  logic                   ar_ok;
  logic [7:0]             awaddr_r;
  logic [31:0]            wdata_r;
  logic                   aw_have_r;
  logic                   w_have_r;
  logic                   do_wr;
  logic                   rd_stat;
  logic [31:0]            rd_val;
  logic [31:0]            status;
  logic                   idle_on_sleep_sel;
  logic                   sys_clk_sel_upper;
  logic [2:0]             internal_freq_sel;

  assign idle_on_sleep_sel = ctrl_r[ircic_pkg::CTL_IDLE];
  assign sys_clk_sel_upper = ctrl_r[ircic_pkg::CTL_SCS_HI];
  assign internal_freq_sel = ctrl_r[ircic_pkg::CTL_FRQ_LSB +: ircic_pkg::FRQ_W];

  assign osc_want = (internal_freq_sel != 3'h0) || ctrl_r[ircic_pkg::CTL_SRC]
                    || ctrl_r[ircic_pkg::CTL_MFP];

  assign enter_idle = sleep_exec && idle_on_sleep_sel
                      && (state_r == ircic_pkg::ST_RUN_INT);

  // AXI write channel capture
  assign aw_ok = s_axi_awvalid && s_axi_awready;
  assign w_ok  = s_axi_wvalid && s_axi_wready;
  assign do_wr = aw_have_r && w_have_r && !s_axi_bvalid;
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      aw_have_r     <= 1'b0;
      w_have_r      <= 1'b0;
      awaddr_r      <= 8'h00;
      wdata_r       <= 32'h0000_0000;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= ircic_pkg::RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= !aw_have_r && !aw_ok && !do_wr;
      s_axi_wready  <= !w_have_r && !w_ok && !do_wr;
      if (aw_ok)
      begin
        aw_have_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (w_ok)
      begin
        w_have_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
      end
      if (do_wr)
      begin
        aw_have_r    <= 1'b0;
        w_have_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_r > ircic_pkg::IMSK_OFS || awaddr_r[1:0] != 2'b00)
                        ? ircic_pkg::RESP_SLVERR : ircic_pkg::RESP_OKAY;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Software-written registers; wake never touches them
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_r     <= ircic_pkg::CTRL_RST;
      stab_len_r <= ircic_pkg::STAB_CYC_RST;
      swd_len_r  <= ircic_pkg::SWD_CYC_RST;
      imsk_r     <= 3'h0;
    end
    else if (do_wr)
    begin
      unique case (awaddr_r)
        ircic_pkg::CTRL_OFS: ctrl_r <= {21'h0, wdata_r[10:0]};
        ircic_pkg::STAB_OFS: stab_len_r <= wdata_r[15:0];
        ircic_pkg::SWD_OFS:  swd_len_r  <= wdata_r[15:0];
        ircic_pkg::IMSK_OFS: imsk_r     <= wdata_r[2:0];
        default: ;
      endcase
    end
  end

  // Status word
  assign status = {25'h0, state_r == ircic_pkg::ST_IDLE_INT, low_freq_rc_en,
                   internal_osc_en, cpu_clk_en, mf_osc_stable_flag,
                   hf_osc_stable_flag, pri_run_r};

  // Read mux
  always_comb
  begin
    unique case (s_axi_araddr)
      ircic_pkg::CTRL_OFS: rd_val = ctrl_r;
      ircic_pkg::STAT_OFS: rd_val = status;
      ircic_pkg::STAB_OFS: rd_val = {16'h0, stab_len_r};
      ircic_pkg::SWD_OFS:  rd_val = {16'h0, swd_len_r};
      ircic_pkg::IRQS_OFS: rd_val = {29'h0, irqs_r};
      ircic_pkg::IMSK_OFS: rd_val = {29'h0, imsk_r};
      default:             rd_val = 32'h0000_0000;
    endcase
  end

  // AXI read channel
  assign ar_ok   = s_axi_arvalid && s_axi_arready;
  assign rd_stat = ar_ok && (s_axi_araddr == ircic_pkg::IRQS_OFS);
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= ircic_pkg::RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !ar_ok;
      if (ar_ok)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_val;
        s_axi_rresp  <= (s_axi_araddr > ircic_pkg::IMSK_OFS || s_axi_araddr[1:0] != 2'b00)
                        ? ircic_pkg::RESP_SLVERR : ircic_pkg::RESP_OKAY;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Clock-mode sequencer
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= ircic_pkg::ST_RUN_PRI;
    end
    else
    begin
      unique case (state_r)
        ircic_pkg::ST_RUN_PRI:
          // Upper select moves to internal mux
          if (sys_clk_sel_upper)
            state_r <= ircic_pkg::ST_RUN_INT;
        ircic_pkg::ST_RUN_INT:
          if (enter_idle)
            state_r <= ircic_pkg::ST_IDLE_INT;
          else if (!sys_clk_sel_upper)
            state_r <= ircic_pkg::ST_RUN_PRI;
        ircic_pkg::ST_IDLE_INT:
          if (wake_event)
            state_r <= ircic_pkg::ST_WAKE;
        ircic_pkg::ST_WAKE:
          if (swd_done)
            state_r <= ircic_pkg::ST_RUN_INT;
      endcase
    end
  end

  // Switch-delay counter
  ircic_delay u_swd
  (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .start   (wake_event && state_r == ircic_pkg::ST_IDLE_INT),
    .abort   (1'b0),
    .len     (swd_len_r),
    .busy    (swd_busy),
    .done    (swd_done)
  );

  // Stabilization counter restarts on each oscillator enable
  ircic_delay u_stab
  (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .start   (osc_want && !osc_want_q),
    .abort   (!osc_want),
    .len     (stab_len_r),
    .busy    (stab_busy),
    .done    (stab_done)
  );

  // Oscillator enable and stable flags
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      osc_want_q         <= 1'b0;
      hf_osc_stable_flag <= 1'b0;
      mf_osc_stable_flag <= 1'b0;
    end
    else
    begin
      osc_want_q <= osc_want;
      if (!osc_want)
      begin
        hf_osc_stable_flag <= 1'b0;
        mf_osc_stable_flag <= 1'b0;
      end
      else if (stab_done)
      begin
        hf_osc_stable_flag <= 1'b1;
        mf_osc_stable_flag <= 1'b1;
      end
    end
  end

  // Clock gate outputs
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cpu_clk_en      <= 1'b1;
      periph_clk_en   <= 1'b1;
      primary_osc_en  <= 1'b1;
      pri_run_r       <= 1'b1;
      internal_osc_en <= 1'b0;
      periph_freq_sel <= 3'h0;
      low_freq_rc_en  <= 1'b0;
    end
    else
    begin
      // CPU gated in idle and wake delay
      cpu_clk_en      <= ((state_r == ircic_pkg::ST_RUN_PRI || state_r == ircic_pkg::ST_RUN_INT)
                         && !enter_idle) || (state_r == ircic_pkg::ST_WAKE && swd_done);
      periph_clk_en   <= 1'b1;
      primary_osc_en  <= (state_r == ircic_pkg::ST_RUN_PRI) && !sys_clk_sel_upper;
      pri_run_r       <= (state_r == ircic_pkg::ST_RUN_PRI) && !sys_clk_sel_upper;
      internal_osc_en <= osc_want;
      periph_freq_sel <= internal_freq_sel;
      // Low-freq RC kept for watchdog or monitor
      low_freq_rc_en  <= ctrl_r[ircic_pkg::CTL_WDT] || ctrl_r[ircic_pkg::CTL_FSCM]
                         || !osc_want || ctrl_r[ircic_pkg::CTL_SRC];
    end
  end

  // Sticky events; read clears, new event wins
  assign ev = {stab_done, swd_done, enter_idle};
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irqs_r <= 3'h0;
      irq    <= 1'b0;
    end
    else
    begin
      irqs_r <= (rd_stat ? 3'h0 : irqs_r) | ev;
      irq    <= |(((rd_stat ? 3'h0 : irqs_r) | ev) & imsk_r);
    end
  end

  // CPU restarts the cycle after the switch delay done pulse
  property p_wake_cpu;
    @(posedge clk_sys) disable iff (!rst_n)
      swd_done |=> cpu_clk_en;
  endproperty
  a_wake_cpu: assert property (p_wake_cpu) else $error("cpu not restarted");

  property p_idle_cpu;
    @(posedge clk_sys) disable iff (!rst_n)
      enter_idle |=> !cpu_clk_en;
  endproperty
  a_idle_cpu: assert property (p_idle_cpu) else $error("cpu clock not stopped");

  property p_periph;
    @(posedge clk_sys) disable iff (!rst_n)
      periph_clk_en;
  endproperty
  a_periph: assert property (p_periph) else $error("peripheral clock lost");

  property p_enter;
    @(posedge clk_sys) disable iff (!rst_n)
      enter_idle |=> state_r == ircic_pkg::ST_IDLE_INT;
  endproperty
  a_enter: assert property (p_enter) else $error("idle not entered");

  property p_pri_off;
    @(posedge clk_sys) disable iff (!rst_n)
      (state_r == ircic_pkg::ST_IDLE_INT) |=> !primary_osc_en && !pri_run_r;
  endproperty
  a_pri_off: assert property (p_pri_off) else $error("primary still on");

  property p_osc_en;
    @(posedge clk_sys) disable iff (!rst_n)
      osc_want |=> internal_osc_en;
  endproperty
  a_osc_en: assert property (p_osc_en) else $error("osc output not enabled");

  property p_off_clear;
    @(posedge clk_sys) disable iff (!rst_n)
      !osc_want |=> !hf_osc_stable_flag && !mf_osc_stable_flag && !internal_osc_en;
  endproperty
  a_off_clear: assert property (p_off_clear) else $error("flags set while off");

  property p_stab_wait;
    @(posedge clk_sys) disable iff (!rst_n)
      $rose(osc_want_q) |-> !hf_osc_stable_flag;
  endproperty
  a_stab_wait: assert property (p_stab_wait) else $error("flag set early");

  property p_keep;
    @(posedge clk_sys) disable iff (!rst_n)
      hf_osc_stable_flag && osc_want |=> hf_osc_stable_flag;
  endproperty
  a_keep: assert property (p_keep) else $error("flag dropped");

  property p_sel_keep;
    @(posedge clk_sys) disable iff (!rst_n)
      (wake_event && !do_wr) |=> $stable(ctrl_r);
  endproperty
  a_sel_keep: assert property (p_sel_keep) else $error("select changed by wake");

  property p_lfrc;
    @(posedge clk_sys) disable iff (!rst_n)
      ctrl_r[ircic_pkg::CTL_WDT] |=> low_freq_rc_en;
  endproperty
  a_lfrc: assert property (p_lfrc) else $error("low-freq rc stopped");
endmodule
`default_nettype wire

// *** ircic_bench.sv ***
// Purpose: self-checking bench for the internal-Internal_state_a clock control
// Assumes: AXI4-Lite master tasks, 50 MHz clock, delays shortened by writes
// Notes: inputs change after the rising edge, outputs sampled at falling
`timescale 1ns/1ps
`default_nettype none
module ircic_bench;
  logic        clk_sys;
  logic        rst_n;
  logic [7:0]  s_axi_awaddr;
  logic        s_axi_awvalid;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_wvalid;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready;
  logic [7:0]  s_axi_araddr;
  logic        s_axi_arvalid;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready;
  logic        sleep_exec;
  logic        wake_event;
  logic        cpu_clk_en;
  logic        periph_clk_en;
  logic        primary_osc_en;
  logic        internal_osc_en;
  logic [2:0]  periph_freq_sel;
  logic        low_freq_rc_en;
  logic        irq;
  int          errors;
  int          samples_checked;
  logic [31:0] d;
  logic [1:0]  r;
  int          n;
  logic        up;
  logic [31:0] tv_ctrl [6] = '{32'h0, 32'h100, 32'h8, 32'h10, 32'h20, 32'h40};
  logic        tv_osc  [6] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};

  ircic_top dut (.clk_sys(clk_sys), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .sleep_exec(sleep_exec), .wake_event(wake_event),
    .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
    .primary_osc_en(primary_osc_en), .internal_osc_en(internal_osc_en),
    .periph_freq_sel(periph_freq_sel), .low_freq_rc_en(low_freq_rc_en), .irq(irq));

  // Clock at 50 MHz
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic give_verdict;
    $display("checks=%0d mismatches=%0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // AXI4-Lite write: address and data offered together, each held to its ready
  task automatic axi_write(input logic [7:0] a, input logic [31:0] wd, output logic [1:0] wr);
    logic aw, w, ah, wh, b;
    int   k;
    aw = 1'b1;
    w = 1'b1;
    b = 1'b0;
    k = 0;
    @(posedge clk_sys);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= wd;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while ((aw || w) && k < 100)
    begin
      @(negedge clk_sys);
      ah = s_axi_awready;
      wh = s_axi_wready;
      @(posedge clk_sys);
      if (aw && ah)
      begin
        s_axi_awvalid <= 1'b0;
        aw = 1'b0;
      end
      if (w && wh)
      begin
        s_axi_wvalid <= 1'b0;
        w = 1'b0;
      end
      k++;
    end
    while (!b && k < 200)
    begin
      @(negedge clk_sys);
      b = s_axi_bvalid;
      wr = s_axi_bresp;
      @(posedge clk_sys);
      k++;
    end
    s_axi_bready <= 1'b0;
  endtask

  // AXI4-Lite read: address held to arready, rready held to rvalid
  task automatic axi_read(input logic [7:0] a, output logic [31:0] rd, output logic [1:0] rr);
    logic hs;
    int   k;
    hs = 1'b0;
    k = 0;
    @(posedge clk_sys);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    while (!hs && k < 100)
    begin
      @(negedge clk_sys);
      hs = s_axi_arready;
      @(posedge clk_sys);
      k++;
    end
    s_axi_arvalid <= 1'b0;
    hs = 1'b0;
    while (!hs && k < 200)
    begin
      @(negedge clk_sys);
      hs = s_axi_rvalid;
      rd = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge clk_sys);
      k++;
    end
    s_axi_rready <= 1'b0;
  endtask

  task automatic pulse(input logic wake);
    @(posedge clk_sys);
    if (wake)
      wake_event <= 1'b1;
    else
      sleep_exec <= 1'b1;
    @(posedge clk_sys);
    wake_event <= 1'b0;
    sleep_exec <= 1'b0;
  endtask

  task automatic settle(input int c);
    repeat (c) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask

  // Peripheral clock must never drop once out of reset
  always @(negedge clk_sys)
    if (rst_n && periph_clk_en !== 1'b1)
    begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, periph_clk_en, 1'b1);
    end

  // Hang guard
  initial
  begin
    repeat (5000) @(posedge clk_sys);
    errors++;
    give_verdict();
  end

  // Main sequence
  initial
  begin
    {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, sleep_exec, wake_event, s_axi_awaddr, s_axi_araddr} = '0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    errors = 0;
    samples_checked = 0;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    settle(1);
    check({cpu_clk_en, primary_osc_en, internal_osc_en, irq}, 32'h0000_000c);
    axi_read(ircic_pkg::CTRL_OFS, d, r);
    check(d, ircic_pkg::CTRL_RST);
    axi_read(ircic_pkg::STAB_OFS, d, r);
    check(d, 32'(ircic_pkg::STAB_CYC_RST));
    axi_read(ircic_pkg::SWD_OFS, d, r);
    check(d, 32'(ircic_pkg::SWD_CYC_RST));
    axi_read(8'h18, d, r);
    check(32'(r), 32'(ircic_pkg::RESP_SLVERR));
    axi_write(8'h18, 32'h1, r);
    check(32'(r), 32'(ircic_pkg::RESP_SLVERR));
    axi_write(ircic_pkg::STAB_OFS, 32'h14, r);
    axi_write(ircic_pkg::SWD_OFS, 32'h2, r);
    // Oscillator output and low-frequency source per control value
    for (int i = 0; i < 6; i++)
    begin
      axi_write(ircic_pkg::CTRL_OFS, tv_ctrl[i], r);
      settle(3);
      check(32'(internal_osc_en), 32'(tv_osc[i]));
      if (tv_ctrl[i][6:5] != 2'b00)
        check(32'(low_freq_rc_en), 32'h1);
      if (!tv_osc[i])
      begin
        axi_read(ircic_pkg::STAT_OFS, d, r);
        check(32'(d[2:1]), 32'h0);
      end
    end
    // Stable flags only after the stabilization interval
    axi_write(ircic_pkg::CTRL_OFS, 32'h300, r);
    axi_read(ircic_pkg::STAT_OFS, d, r);
    check(32'(d[2:1] != 2'b00), 32'h0);
    settle(30);
    axi_read(ircic_pkg::STAT_OFS, d, r);
    check(32'(d[2:1] != 2'b00), 32'h1);
    check(32'(periph_freq_sel), 32'h3);
    // Sleep ignored in primary run, and with idle select clear
    axi_write(ircic_pkg::CTRL_OFS, 32'h301, r);
    pulse(1'b0);
    settle(1);
    check(32'(cpu_clk_en), 32'h1);
    axi_write(ircic_pkg::CTRL_OFS, 32'h304, r);
    settle(2);
    check(32'(primary_osc_en), 32'h0);
    axi_read(ircic_pkg::STAT_OFS, d, r);
    check(32'(d[0]), 32'h0);
    pulse(1'b0);
    settle(1);
    check(32'(cpu_clk_en), 32'h1);
    // Idle entry with the lower select bit set
    axi_write(ircic_pkg::IMSK_OFS, 32'h0, r);
    axi_write(ircic_pkg::CTRL_OFS, 32'h307, r);
    pulse(1'b0);
    settle(1);
    check(32'(cpu_clk_en), 32'h0);
    check(32'(irq), 32'h0);
    axi_read(ircic_pkg::STAT_OFS, d, r);
    check(32'(d[6]), 32'h1);
    check(32'(d[2:1] != 2'b00), 32'h1);
    axi_write(ircic_pkg::IMSK_OFS, 32'h1, r);
    settle(2);
    check(32'(irq), 32'h1);
    axi_read(ircic_pkg::IRQS_OFS, d, r);
    check(32'(d[0]), 32'h1);
    settle(2);
    check(32'(irq), 32'h0);
    // Wake: CPU restarts only after the switch delay
    pulse(1'b1);
    n = 0;
    do
    begin
      @(negedge clk_sys);
      up = cpu_clk_en;
      n++;
    end
    while (!up && n < 50);
    check(32'(n >= 2 && n <= 4), 32'h1);
    check(32'(periph_freq_sel), 32'h3);
    axi_read(ircic_pkg::CTRL_OFS, d, r);
    check(d, 32'h307);
    give_verdict();
  end
endmodule
`default_nettype wire
